// *** tb/fsa_card_model.sv ***
`timescale 1ns/1ns
module fsa_card_model (
  input  wire logic        pclk,
  input  wire logic        sync_on,
  input  wire logic [12:0] gap,
  output logic [2:0]       ref_clk,
  output logic [2:0]       sync_pin
);
  logic [1:0]  phase = 2'h0;
  logic [12:0] cnt = 13'h0;
  // Reference runs at a quarter of pclk; sync falls once per gap cycles.
  always @(posedge pclk) begin
    phase <= phase + 2'h1;
    cnt <= (cnt >= gap - 13'h1) ? 13'h0 : cnt + 13'h1;
  end
  assign ref_clk = {3{phase[1]}};
  // A released sync line is pulled up, so it idles high.
  assign sync_pin = {3{~sync_on | (cnt > 13'h7)}};
endmodule // fsa_card_model

// *** tb/fsa_chk.sv ***
`timescale 1ns/1ns
module fsa_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        primary_loop_tick,
  input wire logic        frame_pulse_output,
  input wire logic        multiframe_pulse_output,
  input wire logic        clock_realign_pulse,
  input wire logic        optical_realign_pulse,
  input wire logic        interrupt_request_pin
);
  logic [10:0] ticks;
  logic [10:0] next_ticks;
  logic        seen;
  logic        next_seen;
  // Ticks since the last frame pulse; a realign may only shorten a frame.
  always_comb begin
    next_seen = seen | frame_pulse_output;
    next_ticks = ticks;
    if (frame_pulse_output) begin
      next_ticks = 11'h0;
    end else if (primary_loop_tick) begin
      next_ticks = ticks + 11'h1;
    end
  end
  // Register the helper state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ticks <= 11'h0;
      seen <= 1'b0;
    end else begin
      ticks <= next_ticks;
      seen <= next_seen;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_read: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read not zero");
  a_frame_period: assert property (seen |-> ticks <= 11'd810)
    else $error("frame period too long");
  a_mf_frame: assert property (
    $rose(multiframe_pulse_output) |-> frame_pulse_output)
    else $error("multiframe off frame");
  a_realign_frame: assert property (
    clock_realign_pulse |-> ##[0:3] frame_pulse_output)
    else $error("realign without frame");
  a_realign_once: assert property (
    clock_realign_pulse |=> !clock_realign_pulse)
    else $error("realign pulse too long");
  a_opt_dep: assert property (
    optical_realign_pulse |-> clock_realign_pulse)
    else $error("optical realign alone");
  a_irq_clear: assert property (
    psel && penable && pready && pwrite && paddr == 8'h0c && pwdata[7]
    |-> ##[1:2] !interrupt_request_pin)
    else $error("request stays after clear");
endmodule // fsa_chk

bind fsa_top fsa_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .primary_loop_tick,
  .frame_pulse_output, .multiframe_pulse_output, .clock_realign_pulse,
  .optical_realign_pulse, .interrupt_request_pin);

// *** tb/tb.sv ***
`timescale 1ns/1ns
module tb;
  import fsa_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  ref_clk;
  logic [2:0]  sync_pin;
  logic        sync_on = 1'b0;
  logic [12:0] gap = 13'd810;
  logic        tick2 = 1'b0;
  logic        is_2k = 1'b0;
  logic        fp;
  logic        mf;
  logic        fq;
  logic        mq;
  logic        g8;
  logic        g2;
  logic        gq8;
  logic        gq2;
  int          n8;
  int          n2;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          nf;
  int          nm;
  int          gaps [3] = '{810, 1620, 3240};

  initial forever #25 pclk = ~pclk;

  fsa_top #(.HOLD_CYCLES(20)) uut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .equipment_clock_input(ref_clk), .paired_frame_input_1(sync_pin[0]),
    .paired_frame_input_2(sync_pin[1]), .paired_frame_input_3(sync_pin[2]),
    .primary_loop_tick(1'b1), .secondary_loop_tick(tick2),
    .ref_is_1944(1'b0), .ref_is_2k(is_2k), .frame_pulse_output(fp),
    .multiframe_pulse_output(mf), .general_8k_output(g8),
    .general_2k_output(g2), .clock_realign_pulse(),
    .optical_realign_pulse(), .interrupt_request_pin(irq));

  fsa_card_model card (.pclk, .sync_on, .gap, .ref_clk, .sync_pin);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready, only the bench timeout ends it.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask

  task test_done;
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Secondary loop ticks and the overall hang limit.
  always @(posedge pclk) begin
    tick2 <= ~tick2;
    cyc++;
    if (cyc == 100000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk(ADDR_OP_STATUS, 32'hff, 32'h2);
    apb(1'b1, ADDR_CTRL, 32'h1ff);
    rchk(ADDR_CTRL, 32'hffffffff, 32'h0);
    repeat (20) @(posedge pclk);
    rchk(ADDR_CTRL, 32'hffffffff, 32'h0);
    rchk(ADDR_OFFSET, 32'hffffffff, 32'h0);
    rchk(ADDR_WINDOW, 32'hffffffff, 32'h20);
    rchk(ADDR_INT_MASK, 32'hffffffff, 32'h0);
    rchk(8'h18, 32'hffffffff, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h1ff);
    rchk(ADDR_CTRL, 32'hffffffff, 32'h1ff);
    apb(1'b1, ADDR_OFFSET, 32'hff);
    rchk(ADDR_OFFSET, 32'hffffffff, 32'h3f);
    apb(1'b1, ADDR_OFFSET, 32'h2);
    apb(1'b1, ADDR_CTRL, 32'h10);
    apb(1'b1, ADDR_INT_MASK, 32'h80);
    sync_on <= 1'b1;
    // Each rate must qualify on its own, with no register change.
    for (int i = 0; i < 3; i++) begin
      gap <= 13'(gaps[i]);
      is_2k <= (i == 2);
      repeat (6 * gaps[i]) @(posedge pclk);
      rchk(ADDR_OP_STATUS, 32'h8f, 32'((i + 1) * 4 + 1));
      apb(1'b1, ADDR_INT_STATUS, 32'h80);
    end
    sync_on <= 1'b0;
    repeat (5000) @(posedge pclk);
    rchk(ADDR_OP_STATUS, 32'h81, 32'h80);
    rchk(ADDR_INT_STATUS, 32'hffffffff, 32'h80);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_INT_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ADDR_INT_MASK, 32'h80);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_INT_STATUS, 32'h0);
    rchk(ADDR_INT_STATUS, 32'hffffffff, 32'h80);
    apb(1'b1, ADDR_INT_STATUS, 32'h80);
    rchk(ADDR_INT_STATUS, 32'hffffffff, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Frames keep their rate with the sync gone.
    nf = 0;
    nm = 0;
    n8 = 0;
    n2 = 0;
    fq = fp;
    mq = mf;
    gq8 = g8;
    gq2 = g2;
    repeat (3240) begin
      @(posedge pclk);
      nf += int'(fp & !fq);
      nm += int'(mf & !mq);
      n8 += int'(g8 & !gq8);
      n2 += int'(g2 & !gq2);
      fq = fp;
      mq = mf;
      gq8 = g8;
      gq2 = g2;
    end
    chk(nf, 4);
    chk(nm, 1);
    chk(n8, 4);
    chk(n2, 1);
    // A reset in mid-run restores defaults and restarts the hold.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(ADDR_OP_STATUS, 32'hff, 32'h2);
    repeat (20) @(posedge pclk);
    rchk(ADDR_CTRL, 32'hffffffff, 32'h0);
    rchk(ADDR_OFFSET, 32'hffffffff, 32'h0);
    test_done();
  end
endmodule // tb

// *** verilog/fsa_div_if.sv ***
`timescale 1ns/1ns
interface fsa_div_if;
  logic       tick;
  logic       load;
  logic       load_mf;
  logic [9:0] count;
  logic [1:0] mf;
  logic       frame_start;

  modport div (input tick, load, load_mf, output count, mf, frame_start);
  modport ctl (output tick, load, load_mf, input count, mf, frame_start);
endinterface

// *** verilog/fsa_divider.sv ***
`timescale 1ns/1ns
module fsa_divider
  import fsa_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  fsa_div_if.div    d
);

  logic [9:0] next_count;
  logic [1:0] next_mf;
  logic       next_start;

  // The frame count moves only on clock ticks and loads, so frames are divided
  // from the output clock and never run on their own timing.
  always_comb begin
    next_count = d.count;
    next_mf    = d.mf;
    next_start = 1'b0;
    if (d.load) begin
      next_count = 10'h000;
      next_start = 1'b1;
      if (d.load_mf) begin
        next_mf = 2'h0;
      end else if (d.count >= FRAME_HALF) begin
        next_mf = d.mf + 2'h1;
      end
    end else if (d.tick) begin
      if (d.count == FRAME_DIV - 10'h001) begin
        next_count = 10'h000;
        next_mf    = (d.mf == MF_LAST) ? 2'h0 : d.mf + 2'h1;
        next_start = 1'b1;
      end else begin
        next_count = d.count + 10'h001;
      end
    end
  end

  // Divider state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d.count       <= 10'h000;
      d.mf          <= 2'h0;
      d.frame_start <= 1'b0;
    end else begin
      d.count       <= next_count;
      d.mf          <= next_mf;
      d.frame_start <= next_start;
    end
  end

endmodule // fsa_divider

// *** verilog/fsa_pin_sync.sv ***
`timescale 1ns/1ns
module fsa_pin_sync (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [5:0] pins,
  output logic [5:0]      level
);

  logic [5:0] s1;
  logic [5:0] s2;
  logic [5:0] s3;

  // Three stages per pin; a change counts once stages two and three agree.
  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_pin
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1[i]    <= 1'b0;
          s2[i]    <= 1'b0;
          s3[i]    <= 1'b0;
          level[i] <= 1'b0;
        end else begin
          s1[i] <= pins[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            level[i] <= s3[i];
          end
        end
      end
    end
  endgenerate

endmodule // fsa_pin_sync

// *** verilog/fsa_pkg.sv ***
package fsa_pkg;

  // Register byte addresses on the APB side.
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_OFFSET     = 8'h04;
  localparam logic [7:0] ADDR_WINDOW     = 8'h08;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_INT_MASK   = 8'h10;
  localparam logic [7:0] ADDR_OP_STATUS  = 8'h14;

  // Register field positions.
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_RES     = 2;
  localparam int CTRL_INDEP   = 3;
  localparam int CTRL_OPT     = 4;
  localparam int CTRL_GEN_AUX = 5;
  localparam int CTRL_INV     = 6;
  localparam int CTRL_WID_LSB = 7;
  localparam int WIN_LSB      = 4;
  localparam int ALARM_BIT    = 7;
  localparam int OP_QUAL_BIT  = 0;
  localparam int OP_HOLD_BIT  = 1;
  localparam int OP_RATE_LSB  = 2;

  // Reset values of the writable registers.
  localparam logic [8:0] CTRL_RST   = 9'h000;
  localparam logic [5:0] OFFSET_RST = 6'h00;
  localparam logic [2:0] WINDOW_RST = 3'h2;
  localparam logic       MASK_RST   = 1'b0;

  // Output clock ticks per 8 kHz frame, frames per multiframe.
  localparam logic [9:0]  FRAME_DIV  = 10'd810;
  localparam logic [9:0]  FRAME_HALF = 10'd405;
  localparam logic [1:0]  MF_LAST    = 2'd3;
  localparam logic [1:0]  MF_HALF    = 2'd2;

  // Expected sync intervals in output clock ticks.
  localparam logic [12:0] INT_8K      = 13'd810;
  localparam logic [12:0] INT_4K      = 13'd1620;
  localparam logic [12:0] INT_2K      = 13'd3240;
  localparam logic [12:0] INT_TIMEOUT = 13'd4000;
  localparam logic [1:0]  QUAL_EDGES  = 2'd3;

  // Hold time after reset release.
  localparam int CLK_HZ  = 20000000;
  localparam int HOLD_MS = 250;
  localparam int HOLD_CYCLES_DEF = HOLD_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    MON_IDLE = 2'b00,
    MON_ACQ  = 2'b01,
    MON_LOCK = 2'b10
  } fsa_mon_t;

  typedef enum logic [1:0] {
    RATE_NONE = 2'b00,
    RATE_8K   = 2'b01,
    RATE_4K   = 2'b10,
    RATE_2K   = 2'b11
  } fsa_rate_t;

endpackage

// *** verilog/fsa_top.sv ***
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module fsa_top
  import fsa_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  equipment_clock_input,
  input  wire logic        paired_frame_input_1,
  input  wire logic        paired_frame_input_2,
  input  wire logic        paired_frame_input_3,
  input  wire logic        primary_loop_tick,
  input  wire logic        secondary_loop_tick,
  input  wire logic        ref_is_1944,
  input  wire logic        ref_is_2k,
  output logic             frame_pulse_output,
  output logic             multiframe_pulse_output,
  output logic             general_8k_output,
  output logic             general_2k_output,
  output logic             clock_realign_pulse,
  output logic             optical_realign_pulse,
  output logic             interrupt_request_pin
);

  fsa_div_if prim ();
  fsa_div_if aux ();

  logic [5:0]  lvl;
  logic [8:0]  ctrl;
  logic [5:0]  offset;
  logic [2:0]  window;
  logic        int_status;
  logic        int_mask;
  logic [22:0] hold_cnt;
  logic        running;
  logic        ref_q;
  logic        samp;
  logic        late_pend;
  logic [1:0]  pair_q;
  logic [12:0] interval;
  fsa_mon_t    mon;
  fsa_rate_t   rate;
  logic [1:0]  good_cnt;
  logic        alarm;
  logic [3:0]  fp_cnt;
  logic [3:0]  mp_cnt;

  logic [8:0]  next_ctrl;
  logic [5:0]  next_offset;
  logic [2:0]  next_window;
  logic        next_int_status;
  logic        next_int_mask;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_irq;
  logic [22:0] next_hold_cnt;
  logic        next_running;
  logic        next_ref_q;
  logic        next_samp;
  logic        next_late_pend;
  logic [1:0]  next_pair_q;
  logic [12:0] next_interval;
  fsa_mon_t    next_mon;
  fsa_rate_t   next_rate;
  logic [1:0]  next_good_cnt;
  logic        next_alarm;
  logic        next_fail;
  logic        next_realign;
  logic        next_realign_mf;
  logic [3:0]  next_fp_cnt;
  logic [3:0]  next_mp_cnt;
  logic        next_fp_out;
  logic        next_mp_out;
  logic        next_g8;
  logic        next_g2;
  logic        next_clk_rl;
  logic        next_opt_rl;

  logic [1:0]  pair;
  logic        ref_lvl;
  logic        sync_lvl;
  logic [1:0]  off_sel;
  logic        ref_rise;
  logic        ref_fall;
  logic        sync_edge;
  logic [12:0] tol;
  logic [9:0]  phase_err;
  logic        freq_ok;
  logic        phase_ok;
  fsa_rate_t   edge_rate;
  logic        wr_en;
  logic [3:0]  width_ticks;

  // All reference and sync pins come from outside this clock domain.
  fsa_pin_sync u_pins (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    ({paired_frame_input_3, paired_frame_input_2,
               paired_frame_input_1, equipment_clock_input}),
    .level   (lvl)
  );

  // Frame dividers for the primary and secondary loops.
  fsa_divider u_prim (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (prim.div)
  );

  fsa_divider u_aux (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (aux.div)
  );

  // Both dividers stay idle while the post-reset hold lasts.
  assign prim.tick    = primary_loop_tick & running;
  assign prim.load    = next_realign;
  assign prim.load_mf = next_realign_mf;
  assign aux.tick     = secondary_loop_tick & running;
  assign aux.load     = 1'b0;
  assign aux.load_mf  = 1'b0;

  // Selection of the locked-to pair and the sampling edge of its sync.
  always_comb begin
    pair     = (ctrl[CTRL_SEL_LSB +: 2] == 2'h3) ? 2'h2
                                                  : ctrl[CTRL_SEL_LSB +: 2];
    ref_lvl  = lvl[pair];
    sync_lvl = lvl[3 + pair];
    off_sel  = offset[2 * pair +: 2];
    ref_rise = ref_lvl & ~ref_q;
    ref_fall = ~ref_lvl & ref_q;
  end

  // Window size in ticks scales with the chosen sample resolution.
  always_comb begin
    tol = {10'h000, window} + 13'h0001;
    if (!ctrl[CTRL_RES]) begin
      tol = tol << 2;
    end else if (ref_is_1944) begin
      tol = tol << 1;
    end
    phase_err = (prim.count <= FRAME_HALF) ? prim.count
                                           : FRAME_DIV - prim.count;
    phase_ok  = {3'h0, phase_err} <= tol;
    edge_rate = RATE_NONE;
    if ((interval + tol >= INT_8K) && (interval <= INT_8K + tol)) begin
      edge_rate = RATE_8K;
    end else if ((interval + tol >= INT_4K) && (interval <= INT_4K + tol)) begin
      edge_rate = RATE_4K;
    end else if ((interval + tol >= INT_2K) && (interval <= INT_2K + tol)) begin
      edge_rate = RATE_2K;
    end
    freq_ok = (edge_rate != RATE_NONE);
  end

  // Sync sampling: only a falling edge counts, seen at the chosen clock
  // edge. A late offset latches on the falling clock edge and commits at
  // the following rising edge, giving half a period of delay.
  always_comb begin
    next_ref_q     = ref_lvl;
    next_samp      = samp;
    next_late_pend = late_pend;
    sync_edge      = 1'b0;
    if (off_sel == 2'h0) begin
      if (ref_rise) begin
        next_samp = sync_lvl;
        sync_edge = samp & ~sync_lvl;
      end
    end else if (ref_fall) begin
      next_samp = sync_lvl;
      if (samp & ~sync_lvl) begin
        if (off_sel[1]) begin
          next_late_pend = 1'b1;
        end else begin
          sync_edge = 1'b1;
        end
      end
    end
    if (late_pend && ref_rise) begin
      next_late_pend = 1'b0;
      sync_edge      = 1'b1;
    end
    if (!running) begin
      sync_edge = 1'b0;
    end
  end

  // Sync quality detector. Edges must arrive at a known rate before the
  // input may steer the dividers, so plugging or pulling a cable cannot
  // cause a spurious jump. Failure raises the alarm and the interrupt status
  // and drops the lock, so the dividers run free; the paired
  // clock stays a valid reference in every case.
  always_comb begin
    next_pair_q     = pair;
    next_mon        = mon;
    next_rate       = rate;
    next_good_cnt   = good_cnt;
    next_alarm      = alarm;
    next_fail       = 1'b0;
    next_realign    = 1'b0;
    next_realign_mf = 1'b0;
    next_interval   = interval;
    if (prim.tick && interval != INT_TIMEOUT) begin
      next_interval = interval + 13'h0001;
    end
    if (!running || pair != pair_q) begin
      next_mon      = MON_IDLE;
      next_good_cnt = 2'h0;
      next_interval = 13'h0000;
    end else if (sync_edge) begin
      next_interval = 13'h0000;
      case (mon)
        MON_IDLE: begin
          next_mon = MON_ACQ;
        end
        MON_ACQ: begin
          if (freq_ok) begin
            next_rate = edge_rate;
            if (good_cnt == QUAL_EDGES - 2'h1) begin
              next_mon        = MON_LOCK;
              next_alarm      = 1'b0;
              next_realign    = 1'b1;
              next_realign_mf = (edge_rate == RATE_2K) & ref_is_2k;
            end else begin
              next_good_cnt = good_cnt + 2'h1;
            end
          end else begin
            next_good_cnt = 2'h0;
          end
        end
        MON_LOCK: begin
          if (freq_ok && phase_ok) begin
            next_rate       = edge_rate;
            next_realign    = (phase_err != 10'h000);
            next_realign_mf = (edge_rate == RATE_2K) & ref_is_2k;
          end else begin
            next_mon      = MON_ACQ;
            next_good_cnt = 2'h0;
            next_alarm    = 1'b1;
            next_fail     = 1'b1;
          end
        end
        default: begin
          next_mon = MON_IDLE;
        end
      endcase
    end else if (interval == INT_TIMEOUT && mon != MON_IDLE) begin
      next_mon      = MON_IDLE;
      next_good_cnt = 2'h0;
      next_rate     = RATE_NONE;
      next_interval = 13'h0000;
      next_alarm    = 1'b1;
      next_fail     = (mon == MON_LOCK);
    end
  end

  // Pulse shaping and the general 2 kHz and 8 kHz squares.
  always_comb begin
    width_ticks = 4'h1 << ctrl[CTRL_WID_LSB +: 2];
    next_fp_cnt = fp_cnt;
    next_mp_cnt = mp_cnt;
    if (prim.frame_start) begin
      next_fp_cnt = width_ticks;
      next_mp_cnt = (prim.mf == 2'h0) ? width_ticks : 4'h0;
    end else if (prim.tick) begin
      next_fp_cnt = (fp_cnt != 4'h0) ? fp_cnt - 4'h1 : 4'h0;
      next_mp_cnt = (mp_cnt != 4'h0) ? mp_cnt - 4'h1 : 4'h0;
    end
    next_fp_out = (next_fp_cnt != 4'h0) ^ ctrl[CTRL_INV];
    next_mp_out = (next_mp_cnt != 4'h0) ^ ctrl[CTRL_INV];
    if (ctrl[CTRL_GEN_AUX]) begin
      next_g8 = aux.count >= FRAME_HALF;
      next_g2 = aux.mf >= MF_HALF;
    end else begin
      next_g8 = prim.count >= FRAME_HALF;
      next_g2 = prim.mf >= MF_HALF;
    end
    next_clk_rl = next_realign & ~ctrl[CTRL_INDEP];
    next_opt_rl = next_realign & ~ctrl[CTRL_INDEP] & ctrl[CTRL_OPT];
  end

  // Post-reset hold: logic waits out the hold time before it runs.
  always_comb begin
    next_hold_cnt = hold_cnt;
    next_running  = running;
    if ({9'h000, hold_cnt} >= HOLD_CYCLES - 1) begin
      next_running = 1'b1;
    end else begin
      next_hold_cnt = hold_cnt + 23'h000001;
    end
  end

  // APB slave: no wait states, write or read completes in the access
  // cycle, unmapped addresses answer with an error and read zero.
  always_comb begin
    wr_en           = psel & penable & pready & pwrite & ~pslverr;
    next_ctrl       = ctrl;
    next_offset     = offset;
    next_window     = window;
    next_int_mask   = int_mask;
    next_int_status = int_status;
    next_prdata     = prdata;
    next_pready     = psel & ~penable & ~pready;
    next_pslverr    = 1'b0;
    if (wr_en && running) begin
      case (paddr)
        ADDR_CTRL:       next_ctrl     = pwdata[8:0];
        ADDR_OFFSET:     next_offset   = pwdata[5:0];
        ADDR_WINDOW:     next_window   = pwdata[WIN_LSB +: 3];
        ADDR_INT_MASK:   next_int_mask = pwdata[ALARM_BIT];
        ADDR_INT_STATUS: begin
          if (pwdata[ALARM_BIT]) begin
            next_int_status = 1'b0;
          end
        end
        default: next_ctrl = ctrl;
      endcase
    end
    if (next_fail) begin
      next_int_status = 1'b1;
    end
    if (psel && !penable) begin
      next_prdata = 32'h00000000;
      case (paddr)
        ADDR_CTRL:       next_prdata[8:0] = ctrl;
        ADDR_OFFSET:     next_prdata[5:0] = offset;
        ADDR_WINDOW:     next_prdata[WIN_LSB +: 3] = window;
        ADDR_INT_STATUS: next_prdata[ALARM_BIT] = int_status;
        ADDR_INT_MASK:   next_prdata[ALARM_BIT] = int_mask;
        ADDR_OP_STATUS: begin
          next_prdata[ALARM_BIT]      = alarm;
          next_prdata[OP_QUAL_BIT]    = (mon == MON_LOCK);
          next_prdata[OP_HOLD_BIT]    = ~running;
          next_prdata[OP_RATE_LSB +: 2] = rate;
        end
        default: next_pslverr = 1'b1;
      endcase
    end else if (pready) begin
      next_pslverr = 1'b0;
    end else begin
      next_pslverr = pslverr;
    end
    next_irq = next_int_status & int_mask;
  end

  // All state is reset to zero except the window, which resets to 2; during the hold the registers keep their defaults.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl                    <= CTRL_RST;
      offset                  <= OFFSET_RST;
      window                  <= WINDOW_RST;
      int_status              <= 1'b0;
      int_mask                <= MASK_RST;
      prdata                  <= 32'h00000000;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
      interrupt_request_pin   <= 1'b0;
      hold_cnt                <= 23'h000000;
      running                 <= 1'b0;
      ref_q                   <= 1'b0;
      samp                    <= 1'b0;
      late_pend               <= 1'b0;
      pair_q                  <= 2'h0;
      interval                <= 13'h0000;
      mon                     <= MON_IDLE;
      rate                    <= RATE_NONE;
      good_cnt                <= 2'h0;
      alarm                   <= 1'b0;
      fp_cnt                  <= 4'h0;
      mp_cnt                  <= 4'h0;
      frame_pulse_output      <= 1'b0;
      multiframe_pulse_output <= 1'b0;
      general_8k_output       <= 1'b0;
      general_2k_output       <= 1'b0;
      clock_realign_pulse     <= 1'b0;
      optical_realign_pulse   <= 1'b0;
    end else begin
      ctrl                    <= next_ctrl;
      offset                  <= next_offset;
      window                  <= next_window;
      int_status              <= next_int_status;
      int_mask                <= next_int_mask;
      prdata                  <= next_prdata;
      pready                  <= next_pready;
      pslverr                 <= next_pslverr;
      interrupt_request_pin   <= next_irq;
      hold_cnt                <= next_hold_cnt;
      running                 <= next_running;
      ref_q                   <= next_ref_q;
      samp                    <= next_samp;
      late_pend               <= next_late_pend;
      pair_q                  <= next_pair_q;
      interval                <= next_interval;
      mon                     <= next_mon;
      rate                    <= next_rate;
      good_cnt                <= next_good_cnt;
      alarm                   <= next_alarm;
      fp_cnt                  <= next_fp_cnt;
      mp_cnt                  <= next_mp_cnt;
      frame_pulse_output      <= next_fp_out;
      multiframe_pulse_output <= next_mp_out;
      general_8k_output       <= next_g8;
      general_2k_output       <= next_g2;
      clock_realign_pulse     <= next_clk_rl;
      optical_realign_pulse   <= next_opt_rl;
    end
  end

endmodule // fsa_top
